// *** core_mem_pkg.sv ***
/*
 * Package for the core memory addressing block: core register offsets,
 * status bit positions, memory sizes, vectors and the carrier structs.
 * Assumes a single clock domain and an execution unit as the only user.
 */
`default_nettype none
package core_mem_pkg;
	localparam logic [4:0] OFF_IND0    = 5'h00;
	localparam logic [4:0] OFF_IND1    = 5'h01;
	localparam logic [4:0] OFF_PCL     = 5'h02;
	localparam logic [4:0] OFF_STATUS  = 5'h03;
	localparam logic [4:0] OFF_P0L     = 5'h04;
	localparam logic [4:0] OFF_P0H     = 5'h05;
	localparam logic [4:0] OFF_P1L     = 5'h06;
	localparam logic [4:0] OFF_P1H     = 5'h07;
	localparam logic [4:0] OFF_BSR     = 5'h08;
	localparam logic [4:0] OFF_WORK    = 5'h09;
	localparam logic [4:0] OFF_PROGRAM_COUNTER_HIGH_LATCH  = 5'h0A;
	localparam logic [4:0] OFF_INTCTL  = 5'h0B;
	localparam logic [4:0] OFF_PERI_LO = 5'h0C;
	localparam logic [6:0] OFF_PERI_HI = 7'h1F;
	localparam logic [6:0] OFF_COMMON  = 7'h70;
	localparam int ST_C  = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z  = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	localparam int PTR_PROG_BIT = 7;
	localparam logic [14:0] RESET_VEC = 15'h0000;
	localparam logic [14:0] INT_VEC   = 15'h0004;
	localparam logic [10:0] PROG_LAST = 11'h7FF;
	localparam int PC_W      = 15;
	localparam int STACK_D   = 16;
	localparam int BANKS     = 32;
	localparam int BANK_SZ   = 128;
	localparam int DADDR_W   = 12;
	localparam logic [7:0] PTR_RST    = 8'h00;
	localparam logic [4:0] STATUS_RST = 5'h18;
	localparam logic [7:0] INTCTL_MASK = 8'hC1;
	localparam logic [7:0] PROGRAM_COUNTER_HIGH_LATCH_MASK = 8'h7F;
	localparam logic [7:0] BSR_MASK    = 8'h1F;

	typedef struct packed {
		logic [7:0] work;
		logic [4:0] status;
		logic [7:0] bank_select;
		logic [7:0] program_counter_high_latch;
		logic [15:0] ptr0;
		logic [15:0] ptr1;
	} shadow_t;

	// one access from the execution unit to the data space
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        indirect;
		logic        sel1;
		logic [6:0]  addr;
		logic [7:0]  wdata;
	} data_req_t;

	// alu flag results of the current instruction
	typedef struct packed {
		logic upd_z;
		logic upd_dc;
		logic upd_c;
		logic z;
		logic dc;
		logic c;
	} flags_t;
endpackage : core_mem_pkg
`default_nettype wire

// *** core_memory_addressing.sv ***
/*
 * Core memory addressing: program counter, return stack, pointers, banked
 * data space, core registers and arithmetic status with write protection.
 * Assumes the execution unit issues at most one data access per cycle and
 * holds requests steady while stall is high; program memory answers in one
 * cycle.
 */
// Notes on behaviour
// - interrupt entry saves working, status, bank select, high latch and both pointers to shadows; return restores them
// - return stack holds sixteen fifteen-bit entries outside data memory
// - overflow or underflow sets its flag; reset option also requests reset
// - two sixteen-bit pointers reach data and program memory space
// - indirect program memory access costs one extra instruction cycle
// - program counter is fifteen bits over a 32K word space
// - program space is 2048 words; higher addresses wrap around
// - reset starts at 0000h; interrupts vector to 0004h
// - pointer high bit 7 selects program memory; low byte goes to working
// - writes through indirect access into program memory do nothing
// - data memory is 32 banks of 128 bytes chosen by bank select
// - unimplemented data locations read as zero
// - data address is twelve bits: five bank bits, seven low bits location
// - twelve core registers sit at the first locations of every bank
// - twenty peripheral locations follow the core registers in each bank
// - alu flag writes to status are ignored when the op sets flags
// - time-out and power-down bits cannot be written by software
// - zero flag at bit 2 marks a zero result
// - time-out bit set on power-up, watchdog clear, sleep; cleared on timeout
// - power-down bit set on power-up, watchdog clear; cleared by sleep
// - digit carry at bit 1 from the fourth bit; inverted for borrow
// - carry at bit 0 from the top bit; rotates load shifted-out bit
`default_nettype none
module core_memory_addressing #(
	parameter int GPR_BYTES = 80,
	parameter int COMMON_BYTES = 16
) (
	input  wire logic                   clk,           // system clock
	input  wire logic                   rst_n,         // async reset
	input  wire logic                   pc_inc,        // advance pc
	input  wire logic                   pc_jump,       // goto/call
	input  wire logic [10:0]            jump_addr,     // literal target
	input  wire logic                   call,          // push and jump
	input  wire logic                   ret,           // pop to pc
	input  wire logic                   int_enter,     // take interrupt
	input  wire logic                   int_ret,       // return from isr
	input  wire logic                   stk_rst_en,    // reset on stack fault
	input  wire logic                   wdt_clear,     // watchdog clear op
	input  wire logic                   sleep_op,      // sleep op
	input  wire logic                   wdt_timeout,   // watchdog expired
	input  wire core_mem_pkg::data_req_t req,          // data access
	input  wire core_mem_pkg::flags_t   flags,         // alu flags
	input  wire logic [13:0]            prog_rdata,    // program word
	output logic [14:0]                 pc,            // program counter
	output logic [14:0]                 prog_addr,     // program fetch addr
	output logic [7:0]                  rdata,         // data read result
	output logic                        stall,         // extra cycle
	output logic [7:0]                  work_out,      // working register
	output logic                        stack_overflow_flag,  // sticky
	output logic                        stack_underflow_flag, // sticky
	output logic                        soft_reset,    // reset request
	output logic [7:0]                  status_out     // status register
);
	localparam int SP_W = $clog2(core_mem_pkg::STACK_D);

	typedef struct packed {
		logic [14:0] pc;
		logic [14:0] paddr;
		logic [SP_W:0] sp;
		logic [7:0]  rdata;
		logic        stall;
		logic [7:0]  work;
		logic [4:0]  status;
		logic [7:0]  bank_select;
		logic [7:0]  program_counter_high_latch;
		logic [7:0]  intctl;
		logic [15:0] ptr0;
		logic [15:0] ptr1;
		logic        ovf;
		logic        unf;
		logic        srst;
		core_mem_pkg::shadow_t shadow;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic [14:0] stack_q [core_mem_pkg::STACK_D];
	logic [7:0] ram_q [core_mem_pkg::BANKS][GPR_BYTES];
	logic [7:0] common_q [COMMON_BYTES];

	// folds any program address into the implemented words
	function automatic logic [14:0] wrap_prog(input logic [14:0] a);
		wrap_prog = {4'h0, a[10:0] & core_mem_pkg::PROG_LAST};
	endfunction : wrap_prog

	logic [15:0] ptr_sel;
	logic [11:0] daddr;
	logic        prog_ind;
	logic        ind_eff;
	logic        push;
	logic        pop;
	logic [6:0]  loc;
	logic        is_gpr;
	logic        is_common;
	logic [6:0]  gpr_idx;
	logic [6:0]  com_idx;

	always_comb
	begin
		// direct access to location 00h or 01h reaches through its pointer
		ind_eff = req.indirect || (req.addr[6:1] == 6'h00);
		ptr_sel = (req.indirect ? req.sel1 : req.addr[0]) ? s_q.ptr1
			: s_q.ptr0;
		// bank from bank select for direct, from pointer for indirect
		daddr = ind_eff ? ptr_sel[11:0]
			: {s_q.bank_select[4:0], req.addr};
		prog_ind = ind_eff && ptr_sel[core_mem_pkg::PTR_PROG_BIT + 8];
		loc = daddr[6:0];
		is_common = loc >= core_mem_pkg::OFF_COMMON;
		is_gpr = (loc > core_mem_pkg::OFF_PERI_HI) && !is_common &&
			(32'(loc) - 32 < GPR_BYTES);
		gpr_idx = 7'(loc - 7'h20);
		com_idx = 7'(loc - core_mem_pkg::OFF_COMMON);
		push = call || int_enter;
		pop = ret || int_ret;
	end

	always_comb
	begin
		s_d = s_q;
		s_d.srst = 1'b0;
		s_d.rdata = 8'h00;
		s_d.stall = 1'b0;
		// program counter
		if (pc_inc)
			s_d.pc = wrap_prog(15'(s_q.pc + 15'h0001));
		if (pc_jump || call)
			s_d.pc = wrap_prog({s_q.program_counter_high_latch[6:3], jump_addr});
		if (int_enter)
			s_d.pc = core_mem_pkg::INT_VEC;
		// stack
		if (push)
		begin
			if (s_q.sp == (SP_W+1)'(core_mem_pkg::STACK_D))
			begin
				s_d.ovf = 1'b1;
				s_d.srst = stk_rst_en;
			end
			else
				s_d.sp = (SP_W+1)'(s_q.sp + 1'b1);
		end
		if (pop)
		begin
			if (s_q.sp == '0)
			begin
				s_d.unf = 1'b1;
				s_d.srst = stk_rst_en;
			end
			else
			begin
				s_d.sp = (SP_W+1)'(s_q.sp - 1'b1);
				s_d.pc = stack_q[SP_W'(s_q.sp - 1'b1)];
			end
		end
		// context save and restore
		if (int_enter)
			s_d.shadow = '{s_q.work, s_q.status, s_q.bank_select, s_q.program_counter_high_latch,
				s_q.ptr0, s_q.ptr1};
		if (int_ret)
		begin
			s_d.work = s_q.shadow.work;
			s_d.status = s_q.shadow.status;
			s_d.bank_select = s_q.shadow.bank_select;
			s_d.program_counter_high_latch = s_q.shadow.program_counter_high_latch;
			s_d.ptr0 = s_q.shadow.ptr0;
			s_d.ptr1 = s_q.shadow.ptr1;
		end
		// indirect program read: first cycle fetches, second returns
		if (req.rd && prog_ind && !s_q.stall)
		begin
			s_d.stall = 1'b1;
			s_d.paddr = wrap_prog(ptr_sel[14:0]);
		end
		else if (req.rd && prog_ind)
			s_d.rdata = prog_rdata[7:0];
		else if (req.rd)
		begin
			unique case (loc)
				7'(core_mem_pkg::OFF_PCL):    s_d.rdata = s_q.pc[7:0];
				7'(core_mem_pkg::OFF_STATUS): s_d.rdata = {3'h0, s_q.status};
				7'(core_mem_pkg::OFF_P0L):    s_d.rdata = s_q.ptr0[7:0];
				7'(core_mem_pkg::OFF_P0H):    s_d.rdata = s_q.ptr0[15:8];
				7'(core_mem_pkg::OFF_P1L):    s_d.rdata = s_q.ptr1[7:0];
				7'(core_mem_pkg::OFF_P1H):    s_d.rdata = s_q.ptr1[15:8];
				7'(core_mem_pkg::OFF_BSR):    s_d.rdata = s_q.bank_select;
				7'(core_mem_pkg::OFF_WORK):   s_d.rdata = s_q.work;
				7'(core_mem_pkg::OFF_PROGRAM_COUNTER_HIGH_LATCH): s_d.rdata = s_q.program_counter_high_latch;
				7'(core_mem_pkg::OFF_INTCTL): s_d.rdata = s_q.intctl;
				default:
				begin
					// peripheral slots belong to other blocks and read zero here
					if (is_gpr)
						s_d.rdata = ram_q[daddr[11:7]][gpr_idx];
					else if (is_common)
						s_d.rdata = common_q[com_idx[3:0]];
				end
			endcase
		end
		if (req.wr && !prog_ind)
		begin
			unique case (loc)
				7'(core_mem_pkg::OFF_PCL):
					s_d.pc = wrap_prog({s_q.program_counter_high_latch[6:0], req.wdata});
				7'(core_mem_pkg::OFF_STATUS):
				begin
					// bits 4:3 are never written
					if (!flags.upd_z) s_d.status[core_mem_pkg::ST_Z] = req.wdata[2];
					if (!flags.upd_dc) s_d.status[core_mem_pkg::ST_DC] = req.wdata[1];
					if (!flags.upd_c) s_d.status[core_mem_pkg::ST_C] = req.wdata[0];
				end
				7'(core_mem_pkg::OFF_P0L):    s_d.ptr0[7:0] = req.wdata;
				7'(core_mem_pkg::OFF_P0H):    s_d.ptr0[15:8] = req.wdata;
				7'(core_mem_pkg::OFF_P1L):    s_d.ptr1[7:0] = req.wdata;
				7'(core_mem_pkg::OFF_P1H):    s_d.ptr1[15:8] = req.wdata;
				7'(core_mem_pkg::OFF_BSR):    s_d.bank_select = req.wdata & core_mem_pkg::BSR_MASK;
				7'(core_mem_pkg::OFF_WORK):   s_d.work = req.wdata;
				7'(core_mem_pkg::OFF_PROGRAM_COUNTER_HIGH_LATCH): s_d.program_counter_high_latch = req.wdata & core_mem_pkg::PROGRAM_COUNTER_HIGH_LATCH_MASK;
				7'(core_mem_pkg::OFF_INTCTL): s_d.intctl = req.wdata & core_mem_pkg::INTCTL_MASK;
				default:
				begin
				end
			endcase
		end
		// program indirect read lands in the working register
		if (req.rd && prog_ind && s_q.stall)
			s_d.work = prog_rdata[7:0];
		if (flags.upd_z) s_d.status[core_mem_pkg::ST_Z] = flags.z;
		if (flags.upd_dc) s_d.status[core_mem_pkg::ST_DC] = flags.dc;
		if (flags.upd_c) s_d.status[core_mem_pkg::ST_C] = flags.c;
		if (wdt_clear || sleep_op)
			s_d.status[core_mem_pkg::ST_TO] = 1'b1;
		if (wdt_timeout)
			s_d.status[core_mem_pkg::ST_TO] = 1'b0;
		if (wdt_clear)
			s_d.status[core_mem_pkg::ST_PD] = 1'b1;
		if (sleep_op)
			s_d.status[core_mem_pkg::ST_PD] = 1'b0;
		if (!s_d.stall)
			s_d.paddr = s_d.pc;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.pc <= core_mem_pkg::RESET_VEC;
			s_q.paddr <= core_mem_pkg::RESET_VEC;
			s_q.status <= core_mem_pkg::STATUS_RST;
		end
		else
			s_q <= s_d;
	end

	// memories hold no reset: contents are undefined after power-up
	always_ff @(posedge clk)
	begin
		if (push && s_q.sp != (SP_W+1)'(core_mem_pkg::STACK_D))
			stack_q[SP_W'(s_q.sp)] <= int_enter ? s_q.pc
				: wrap_prog(15'(s_q.pc + 15'h0001));
		if (req.wr && !prog_ind && is_gpr)
			ram_q[daddr[11:7]][gpr_idx] <= req.wdata;
		if (req.wr && !prog_ind && is_common)
			common_q[com_idx[3:0]] <= req.wdata;
	end

	assign pc = s_q.pc;
	assign prog_addr = s_q.paddr;
	assign rdata = s_q.rdata;
	assign stall = s_q.stall;
	assign work_out = s_q.work;
	assign stack_overflow_flag = s_q.ovf;
	assign stack_underflow_flag = s_q.unf;
	assign soft_reset = s_q.srst;
	assign status_out = {3'h0, s_q.status};

	// stack fault and program read steps shared by the checks below
	sequence push_full_s;
		push && s_q.sp == 5'd16;
	endsequence

	sequence pop_empty_s;
		pop && s_q.sp == 5'd0;
	endsequence

	sequence prog_start_s;
		req.rd && prog_ind && !stall;
	endsequence

	sequence prog_finish_s;
		stall ##1 !stall;
	endsequence

	chk_ovf_flag_set: assert property (
		@(posedge clk) disable iff (!rst_n)
		push_full_s |=> stack_overflow_flag)
		else $error("overflow flag not set");
	chk_ovf_reset_req: assert property (
		@(posedge clk) disable iff (!rst_n)
		push_full_s and stk_rst_en |=> soft_reset)
		else $error("no reset on overflow");
	chk_unf_flag_set: assert property (
		@(posedge clk) disable iff (!rst_n)
		pop_empty_s |=> stack_underflow_flag)
		else $error("underflow flag not set");
	chk_unf_reset_req: assert property (
		@(posedge clk) disable iff (!rst_n)
		pop_empty_s and stk_rst_en |=> soft_reset)
		else $error("no reset on underflow");
	chk_ovf_sticky: assert property (
		@(posedge clk) disable iff (!rst_n)
		stack_overflow_flag |=> stack_overflow_flag)
		else $error("overflow flag cleared");
	chk_unf_sticky: assert property (
		@(posedge clk) disable iff (!rst_n)
		stack_underflow_flag |=> stack_underflow_flag)
		else $error("underflow flag cleared");
	chk_stack_depth: assert property (
		@(posedge clk) disable iff (!rst_n)
		s_q.sp <= 5'd16)
		else $error("stack pointer beyond depth");
	chk_prog_extra_cycle: assert property (
		@(posedge clk) disable iff (!rst_n)
		prog_start_s |=> prog_finish_s)
		else $error("program read not one extra cycle");
	chk_prog_to_work: assert property (
		@(posedge clk) disable iff (!rst_n)
		stall && req.rd |=> work_out == rdata)
		else $error("program byte not in working register");
	chk_int_vector: assert property (
		@(posedge clk) disable iff (!rst_n)
		int_enter |=> pc == 15'h0004)
		else $error("interrupt vector wrong");
	chk_reset_vector: assert property (
		@(posedge clk)
		$rose(rst_n) |-> pc == 15'h0000)
		else $error("reset vector wrong");
	chk_jump_target: assert property (
		@(posedge clk) disable iff (!rst_n)
		(pc_jump || call) && !int_enter && !pop && !req.wr
		|=> pc == {4'h0, $past(jump_addr)})
		else $error("jump target wrong");
	chk_pc_wraps: assert property (
		@(posedge clk) disable iff (!rst_n)
		pc[14:11] == 4'h0)
		else $error("pc beyond program space");
	chk_int_saves: assert property (
		@(posedge clk) disable iff (!rst_n)
		int_enter |=> s_q.shadow.work == $past(work_out))
		else $error("working register not saved");
	chk_ret_restores: assert property (
		@(posedge clk) disable iff (!rst_n)
		int_ret && !req.rd && !req.wr |=> work_out == $past(s_q.shadow.work))
		else $error("working register not restored");
	chk_to_pd_sleep: assert property (
		@(posedge clk) disable iff (!rst_n)
		sleep_op && !wdt_timeout |=> status_out[4:3] == 2'b10)
		else $error("sleep status bits wrong");
	chk_flag_wins: assert property (
		@(posedge clk) disable iff (!rst_n)
		flags.upd_z |=> status_out[2] == $past(flags.z))
		else $error("zero flag not from alu");
	chk_ro_bits: assert property (
		@(posedge clk) disable iff (!rst_n)
		!wdt_clear && !sleep_op && !wdt_timeout && !int_ret
		|=> $stable(status_out[4:3]))
		else $error("status read-only bits changed");
	chk_idle_read_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		!req.rd |=> rdata == 8'h00)
		else $error("read data not idle");
endmodule : core_memory_addressing
`default_nettype wire

// *** prog_rom_model.sv ***
/*
 * Program memory model facing the core memory addressing block.
 * Assumes the block presents a fifteen-bit word address and reads the
 * fourteen-bit word back in the same cycle (asynchronous read).
 */
`default_nettype none
module prog_rom_model (
	input  wire logic [14:0] addr, // fetch address
	output logic      [13:0] word  // addressed word
);
	timeunit 1ns;
	timeprecision 1ps;
	// only eleven address bits decode, so higher addresses alias
	always_comb
	begin
		word = {addr[10:0], 3'h6} ^ 14'h02A5;
	end
endmodule : prog_rom_model
`default_nettype wire

// *** tb_core_memory_addressing.sv ***
/*
 * Self-checking bench for core_memory_addressing: register rows first,
 * then jumps, interrupt, program reads, flags, stack by hand.
 * Assumes prog_rom_model answers fetches within the cycle.
 */
`default_nettype none
module tb_core_memory_addressing;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} row_t;
	logic                    clk, rst_n, pc_inc, pc_jump, call, ret;
	logic                    int_enter, int_ret, stk_rst_en, wdt_clear;
	logic                    sleep_op, wdt_timeout, stall, ovf, unf;
	logic                    soft_reset, seen;
	logic [10:0]             jump_addr;
	logic [13:0]             prog_rdata;
	logic [14:0]             pc, prog_addr;
	logic [7:0]              rdata, work_out, status_out;
	core_mem_pkg::data_req_t req;
	core_mem_pkg::flags_t    flags;
	int                      fails, check_count, cycles;
	// bank select goes first so the rest run in bank 31; location 00h
	// reaches through pointer 0, set by the rows before it
	row_t rows [15] = '{
		'{7'h08, 8'hFF, 8'h1F}, '{7'h09, 8'h96, 8'h96},
		'{7'h04, 8'hA5, 8'hA5}, '{7'h05, 8'h3C, 8'h3C},
		'{7'h06, 8'hC3, 8'hC3}, '{7'h07, 8'h81, 8'h81},
		'{7'h00, 8'h6B, 8'h6B},
		'{7'h0A, 8'hFF, 8'h7F}, '{7'h0B, 8'hFF, 8'hC1},
		'{7'h03, 8'hFF, 8'h1F}, '{7'h0C, 8'hAA, 8'h00},
		'{7'h1F, 8'h55, 8'h00}, '{7'h20, 8'h5A, 8'h5A},
		'{7'h6F, 8'h33, 8'h33}, '{7'h70, 8'h3C, 8'h3C}
	};

	core_memory_addressing DUT (
		.clk(clk), .rst_n(rst_n), .pc_inc(pc_inc), .pc_jump(pc_jump),
		.jump_addr(jump_addr), .call(call), .ret(ret),
		.int_enter(int_enter), .int_ret(int_ret), .stk_rst_en(stk_rst_en),
		.wdt_clear(wdt_clear), .sleep_op(sleep_op),
		.wdt_timeout(wdt_timeout), .req(req), .flags(flags),
		.prog_rdata(prog_rdata), .pc(pc), .prog_addr(prog_addr),
		.rdata(rdata), .stall(stall), .work_out(work_out),
		.stack_overflow_flag(ovf), .stack_underflow_flag(unf),
		.soft_reset(soft_reset), .status_out(status_out)
	);
	prog_rom_model rom (
		.addr(prog_addr),
		.word(prog_rdata)
	);

	always #4 clk = ~clk;

	task automatic conclude();
		if (fails == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// ends every pulse after one cycle, then lets the edge settle
	task automatic step();
		@(posedge clk);
		{pc_inc, pc_jump, call, ret, int_enter, int_ret} <= '0;
		{wdt_clear, sleep_op, wdt_timeout} <= '0;
		#1;
	endtask : step

	task automatic access(input logic rd, input logic wr, input logic ind,
		input logic sel, input logic [6:0] a, input logic [7:0] d,
		input core_mem_pkg::flags_t f);
		@(posedge clk);
		req <= '{rd, wr, ind, sel, a, d};
		flags <= f;
		@(posedge clk);
		req <= '0;
		flags <= '0;
		#1;
	endtask : access

	// the request must stay up through the stall cycle
	task automatic prog_read(input logic [7:0] exp);
		@(posedge clk);
		req <= '{1'b1, 1'b0, 1'b1, 1'b0, 7'h00, 8'h00};
		@(posedge clk);
		#1;
		check(16'(stall), 16'h0001);
		check(16'(prog_addr), 16'h0105);
		@(posedge clk);
		req <= '0;
		#1;
		check(16'(stall), 16'h0000);
		check(16'(rdata), 16'(exp));
		check(16'(work_out), 16'(exp));
	endtask : prog_read

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check(16'(pc), 16'h0000);
		check(16'(status_out), 16'h0018);
		check(16'({ovf, unf}), 16'h0000);
	endtask : do_reset

	task automatic event_op(input int k, input logic [7:0] exp);
		@(posedge clk);
		sleep_op <= (k == 0);
		wdt_timeout <= (k == 1);
		wdt_clear <= (k == 2);
		step();
		check(16'(status_out), 16'(exp));
	endtask : event_op

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			conclude();
		end
	end

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		{pc_inc, pc_jump, call, ret, int_enter, int_ret} = '0;
		{stk_rst_en, wdt_clear, sleep_op, wdt_timeout} = '0;
		jump_addr = '0;
		req = '0;
		flags = '0;
		do_reset();
		foreach (rows[i])
		begin
			access(0, 1, 0, 0, rows[i].addr, rows[i].wdata, '0);
			access(1, 0, 0, 0, rows[i].addr, 8'h00, '0);
			check(16'(rdata), 16'(rows[i].exp));
		end
		check(16'(status_out), 16'h001F);
		// high latch is 7Fh, yet the target must fold into 2048 words
		@(posedge clk);
		pc_jump <= 1'b1;
		jump_addr <= 11'h7FF;
		step();
		check(16'(pc), 16'h07FF);
		@(posedge clk);
		pc_inc <= 1'b1;
		step();
		check(16'(pc), 16'h0000);
		@(posedge clk);
		pc_jump <= 1'b1;
		jump_addr <= 11'h050;
		step();
		access(0, 1, 0, 0, 7'h09, 8'h42, '0);
		@(posedge clk);
		int_enter <= 1'b1;
		step();
		check(16'(pc), 16'h0004);
		access(0, 1, 0, 0, 7'h09, 8'h99, '0);
		@(posedge clk);
		int_ret <= 1'b1;
		step();
		check(16'(pc), 16'h0050);
		check(16'(work_out), 16'h0042);
		access(0, 1, 0, 0, 7'h05, 8'h81, '0);
		access(0, 1, 0, 0, 7'h04, 8'h05, '0);
		prog_read(8'h8B);
		// an ungated write would land on the pointer's high byte
		access(0, 1, 1, 0, 7'h00, 8'hEE, '0);
		access(1, 0, 0, 0, 7'h05, 8'h00, '0);
		check(16'(rdata), 16'h0081);
		access(0, 1, 0, 0, 7'h05, 8'h89, '0);
		prog_read(8'h8B);
		access(0, 1, 0, 0, 7'h07, 8'h00, '0);
		access(0, 1, 0, 0, 7'h06, 8'hA5, '0);
		access(0, 1, 1, 1, 7'h00, 8'h77, '0);
		access(0, 1, 0, 0, 7'h08, 8'h01, '0);
		access(1, 0, 0, 0, 7'h25, 8'h00, '0);
		check(16'(rdata), 16'h0077);
		access(0, 1, 0, 0, 7'h03, 8'h00, 6'h24);
		check(16'(status_out), 16'h001C);
		access(0, 0, 0, 0, 7'h00, 8'h00, 6'h09);
		check(16'(status_out), 16'h001D);
		access(0, 0, 0, 0, 7'h00, 8'h00, 6'h12);
		check(16'(status_out), 16'h001F);
		access(0, 0, 0, 0, 7'h00, 8'h00, 6'h20);
		check(16'(status_out), 16'h001B);
		event_op(0, 8'h13);
		event_op(1, 8'h03);
		event_op(2, 8'h1B);
		do_reset();
		for (int i = 0; i < 17; i++)
		begin
			@(posedge clk);
			stk_rst_en <= 1'b1;
			call <= 1'b1;
			jump_addr <= 11'h100 + 11'(i);
			step();
			if (i == 15)
				check(16'(ovf), 16'h0000);
		end
		seen = soft_reset;
		repeat (2)
		begin
			@(posedge clk);
			#1;
			seen = seen | soft_reset;
		end
		check(16'(ovf), 16'h0001);
		check(16'(seen), 16'h0001);
		for (int k = 15; k >= 0; k--)
		begin
			@(posedge clk);
			ret <= 1'b1;
			step();
			check(16'(pc), (k == 0) ? 16'h0001 : 16'h0100 + 16'(k));
		end
		@(posedge clk);
		ret <= 1'b1;
		step();
		check(16'(unf), 16'h0001);
		check(16'(soft_reset), 16'h0001);
		conclude();
	end
endmodule : tb_core_memory_addressing
`default_nettype wire
